/* File: dpc_defs.svh */
// register addresses, field positions and reset values of the dual port block
// assumes: included by bare name wherever these names are used
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

`define DPC_ADDR_PORT_CONFIG 8'h00
`define DPC_ADDR_WIDE_DATA 8'h02
`define DPC_ADDR_NARROW_DATA 8'h03
`define DPC_ADDR_WIDE_MODE 8'h06
`define DPC_ADDR_NARROW_MODE 8'h07
`define DPC_ADDR_PULLUP 8'h08
`define DPC_ADDR_IRQ_EDGE 8'h0A
`define DPC_ADDR_STOP_SEL 8'h0B
`define DPC_ADDR_ADC_CTRL 8'h0C
`define DPC_ADDR_ADC_RESULT 8'h0D

`define DPC_RESET_BYTE 8'h00
`define DPC_WIDE_DIR_RESET 8'hFF
`define DPC_IRQ_NONE 3'h0

`define DPC_PORT_CONFIG_COMP_OUT 0
`define DPC_NMODE_LOW_EMI 0
`define DPC_NMODE_ANALOG 1
`define DPC_NMODE_WIDE_HS 2
`define DPC_NMODE_P0_HS 3
`define DPC_NMODE_TIMER_OUT 5
`define DPC_IRQ_SEL_LO 6
`define DPC_IRQ_SEL_HI 7
`define DPC_STOP_SEL_HI 1
`define DPC_STOP_SEL_LO 0
`define DPC_ADC_CH_HI 2
`define DPC_ADC_CH_LO 0

`define DPC_LINE_ONE 0
`define DPC_LINE_TWO 1
`define DPC_LINE_THREE 2
`define DPC_OUT_FOUR 4
`define DPC_OUT_FIVE 5
`define DPC_OUT_SIX 6

`define DPC_REQ_ZERO 0
`define DPC_REQ_ONE 1
`define DPC_REQ_TWO 2

`endif

/* File: dpc_pkg.sv */
// types shared by the dual port block
// assumes: nothing beyond the compiler
package dpc_pkg;

   typedef logic [7:0] dpc_byte_t;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dpc_reg_req_s;

   typedef struct packed
   {
      logic six;
      logic five;
      logic four;
   } dpc_narrow_out_s;

endpackage : dpc_pkg

/* File: dpc_sync3.sv */
// three-stage synchroniser for pin-side levels
// assumes: async_in comes from outside the clock domain
`timescale 1ns/1ps
module dpc_sync3 #(parameter int WIDTH = 8)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] stage_two;
   logic [WIDTH-1:0] stage_three;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         stage_one <= '0;
         stage_two <= '0;
         stage_three <= '0;
      end
      else if (clock_enable)
      begin
         stage_one <= async_in;
         stage_two <= stage_one;
         stage_three <= stage_two;
      end
   end

   // a bit moves only once stages two and three agree, filtering one-cycle glitches
   always_ff @(posedge clock)
   begin
      if (reset)
         sync_out <= '0;
      else if (clock_enable)
         sync_out <= (stage_two & ~(stage_two ^ stage_three)) | (sync_out & (stage_two ^ stage_three));
   end

endmodule : dpc_sync3

/* File: dpc_edge_irq.sv */
// edge detector giving a one-cycle request pulse on selected edges
// assumes: level is already synchronised to clock
`timescale 1ns/1ps
module dpc_edge_irq
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic level,
   input wire logic rise_en,
   input wire logic fall_en,
   output logic pulse
);

   logic prev;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         prev <= 1'b0;
         pulse <= 1'b0;
      end
      else if (clock_enable)
      begin
         prev <= level;
         pulse <= (rise_en & level & ~prev) | (fall_en & ~level & prev);
      end
   end

endmodule : dpc_edge_irq

/* File: dpc_port_top.sv */
// eight-line port, six-line port, comparators and port configuration register
// assumes: register strobes come from the core on clock; pins and comparators are asynchronous
// Function
// RQ1: per-line direction; inputs read back pin levels
// RQ2: eight-line port feeds converter channel mux
// RQ3: pull-up only on selected input lines
// RQ4: lines one-three inputs, four-six outputs
// RQ5: global low-emission drive mode bit
// RQ6: mode bit 1 selects analog comparator mode
// RQ7: line three falling edge raises request one
// RQ8: lines one, two edge-selectable interrupts
// RQ9: edge select pair encoding for lines
// RQ10: requests zero-two from lines two, three, one
// RQ11: timer input line one, output line six
// RQ12: handshake pairs on lines two/five, one/six
// RQ13: analog mode: stop recovery toggles line three
// RQ14: digital mode: line three plain or interrupt
// RQ15: config bit 0 routes comparator one out
// RQ16: comparator two stays internal only
// RQ17: config register cleared by reset, watchdog; code keeps it on watchdog reset in stop mode
// RQ18: software waits and masks around mode switch
// RQ19: lines one-three plain inputs, no keepers
// RQ20: async inputs synchronised before use
`timescale 1ns/1ps
`include "dpc_defs.svh"
module dpc_port_top
   import dpc_pkg::*;
#(
   parameter int WIDE_WIDTH = 8,
   parameter int STOP_SOURCES = 4
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire dpc_reg_req_s reg_req,
   output dpc_byte_t reg_rdata,
   input wire logic watchdog_reset,
   input wire logic stop_mode,
   input wire logic [WIDE_WIDTH-1:0] wide_pin_in,
   output logic [WIDE_WIDTH-1:0] wide_pin_out,
   output logic [WIDE_WIDTH-1:0] wide_pin_oe,
   output logic [WIDE_WIDTH-1:0] wide_pullup_en,
   output logic [2:0] adc_channel,
   input wire dpc_byte_t adc_result,
   input wire logic [2:0] narrow_pin_in,
   input wire logic comp_one_raw,
   input wire logic comp_two_raw,
   output dpc_narrow_out_s narrow_pins,
   output logic low_emi_mode,
   output logic analog_mode_en,
   input wire logic [STOP_SOURCES-1:0] stop_src,
   output logic [2:0] ext_request,
   output logic comp_two_level,
   output logic timer_ext_in,
   input wire logic timer_out,
   output logic p0_hs_in,
   input wire logic p0_hs_out,
   output logic wide_hs_in,
   input wire logic wide_hs_out
);

   localparam int SYNC_WIDTH = WIDE_WIDTH + 3 + 2 + STOP_SOURCES;

   dpc_byte_t port_config;
   dpc_byte_t wide_data;
   dpc_byte_t wide_dir;
   dpc_byte_t wide_pullup_select;
   dpc_byte_t narrow_data;
   dpc_byte_t narrow_mode_reg;
   dpc_byte_t irq_edge;
   dpc_byte_t stop_recovery_select;
   dpc_byte_t adc_ctrl;

   logic [SYNC_WIDTH-1:0] sync_lvl;
   logic [WIDE_WIDTH-1:0] wide_lvl;
   logic [2:0] narrow_lvl;
   logic comp_one_lvl;
   logic comp_two_lvl;
   logic [STOP_SOURCES-1:0] stop_lvl;
   logic analog;
   logic line_one_val;
   logic line_two_val;
   logic line_three_val;
   logic line_three_toggle;
   logic stop_level;
   logic stop_pulse;
   logic line_one_pulse;
   logic line_two_pulse;
   logic line_three_pulse;
   logic one_rise;
   logic one_fall;
   logic two_rise;
   logic two_fall;
   logic next_request_one;
   logic port_config_write;
   dpc_byte_t next_rdata;

   // rising/falling enables for one line; other_bit wins the shared both-edges code
   function automatic logic [1:0] edge_sel(input logic own_bit, input logic other_bit);
      edge_sel = {own_bit, ~own_bit | other_bit};
   endfunction : edge_sel

   function automatic logic reg_hit(input dpc_reg_req_s req, input logic [7:0] addr);
      reg_hit = req.wr && (req.addr == addr);
   endfunction : reg_hit

   // every pin-side level passes three synchroniser flops and the filter flop before it is looked at
   dpc_sync3 #(.WIDTH(SYNC_WIDTH)) u_sync
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .async_in({stop_src, comp_two_raw, comp_one_raw, narrow_pin_in, wide_pin_in}), // see RQ20
      .sync_out(sync_lvl)
   );

   assign wide_lvl = sync_lvl[WIDE_WIDTH-1:0];
   assign narrow_lvl = sync_lvl[WIDE_WIDTH+2:WIDE_WIDTH]; // see RQ19
   assign comp_one_lvl = sync_lvl[WIDE_WIDTH+3];
   assign comp_two_lvl = sync_lvl[WIDE_WIDTH+4];
   assign stop_lvl = sync_lvl[SYNC_WIDTH-1:WIDE_WIDTH+5];

   assign analog = narrow_mode_reg[`DPC_NMODE_ANALOG]; // see RQ6
   assign line_one_val = analog ? comp_one_lvl : narrow_lvl[`DPC_LINE_ONE]; // see RQ6
   assign line_two_val = analog ? comp_two_lvl : narrow_lvl[`DPC_LINE_TWO];
   assign line_three_val = analog ? line_three_toggle : narrow_lvl[`DPC_LINE_THREE]; // see RQ14
   assign stop_level = stop_lvl[stop_recovery_select[`DPC_STOP_SEL_HI:`DPC_STOP_SEL_LO]];

   assign {one_rise, one_fall} = edge_sel(irq_edge[`DPC_IRQ_SEL_HI], irq_edge[`DPC_IRQ_SEL_LO]); // see RQ9
   assign {two_rise, two_fall} = edge_sel(irq_edge[`DPC_IRQ_SEL_LO], irq_edge[`DPC_IRQ_SEL_HI]); // see RQ9

   // line one and two interrupts follow the comparator in analog mode
   dpc_edge_irq u_edge_one
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .level(line_one_val),
      .rise_en(one_rise), // see RQ8
      .fall_en(one_fall),
      .pulse(line_one_pulse)
   );

   dpc_edge_irq u_edge_two
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .level(line_two_val),
      .rise_en(two_rise), // see RQ8
      .fall_en(two_fall),
      .pulse(line_two_pulse)
   );

   dpc_edge_irq u_edge_three
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .level(narrow_lvl[`DPC_LINE_THREE]),
      .rise_en(1'b0),
      .fall_en(1'b1), // see RQ7
      .pulse(line_three_pulse)
   );

   dpc_edge_irq u_edge_stop
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .level(stop_level),
      .rise_en(1'b1),
      .fall_en(1'b0),
      .pulse(stop_pulse)
   );

   assign port_config_write = reg_hit(reg_req, `DPC_ADDR_PORT_CONFIG);

   // watchdog reset in stop mode leaves the configuration alone
   always_ff @(posedge clock)
   begin
      if (reset)
         port_config <= `DPC_RESET_BYTE; // see RQ17
      else if (clock_enable)
      begin
         if (watchdog_reset && !stop_mode)
            port_config <= `DPC_RESET_BYTE; // see RQ17
         else if (port_config_write)
            port_config <= reg_req.wdata;
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wide_data <= `DPC_RESET_BYTE;
         wide_dir <= `DPC_WIDE_DIR_RESET;
         wide_pullup_select <= `DPC_RESET_BYTE;
         narrow_data <= `DPC_RESET_BYTE;
         narrow_mode_reg <= `DPC_RESET_BYTE;
         irq_edge <= `DPC_RESET_BYTE;
         stop_recovery_select <= `DPC_RESET_BYTE;
         adc_ctrl <= `DPC_RESET_BYTE;
      end
      else if (clock_enable)
      begin
         if (reg_hit(reg_req, `DPC_ADDR_WIDE_DATA))
            wide_data <= reg_req.wdata;
         if (reg_hit(reg_req, `DPC_ADDR_WIDE_MODE))
            wide_dir <= reg_req.wdata; // see RQ1
         if (reg_hit(reg_req, `DPC_ADDR_PULLUP))
            wide_pullup_select <= reg_req.wdata;
         if (reg_hit(reg_req, `DPC_ADDR_NARROW_DATA))
            narrow_data <= reg_req.wdata;
         if (reg_hit(reg_req, `DPC_ADDR_NARROW_MODE))
            narrow_mode_reg <= reg_req.wdata;
         if (reg_hit(reg_req, `DPC_ADDR_IRQ_EDGE))
            irq_edge <= reg_req.wdata;
         if (reg_hit(reg_req, `DPC_ADDR_STOP_SEL))
            stop_recovery_select <= reg_req.wdata;
         if (reg_hit(reg_req, `DPC_ADDR_ADC_CTRL))
            adc_ctrl <= reg_req.wdata; // see RQ2
      end
   end

   // the internal line-three bit flips on each selected recovery event in analog mode
   always_ff @(posedge clock)
   begin
      if (reset)
         line_three_toggle <= 1'b0;
      else if (clock_enable && analog && stop_pulse)
         line_three_toggle <= ~line_three_toggle; // see RQ13
   end

   assign next_request_one = analog ? stop_pulse : line_three_pulse; // see RQ13

   always_ff @(posedge clock)
   begin
      if (reset)
         ext_request <= `DPC_IRQ_NONE;
      else if (clock_enable)
      begin
         ext_request[`DPC_REQ_ZERO] <= line_two_pulse; // see RQ10
         ext_request[`DPC_REQ_ONE] <= next_request_one; // see RQ10
         ext_request[`DPC_REQ_TWO] <= line_one_pulse; // see RQ10
      end
   end

   // output latch returned for output lines, pin level for input lines; in analog mode lines one-three return comparator and toggle levels
   always_comb
   begin
      next_rdata = `DPC_RESET_BYTE;
      unique case (reg_req.addr)
         `DPC_ADDR_WIDE_DATA: next_rdata = (wide_lvl & wide_dir) | (wide_data & ~wide_dir); // see RQ1
         `DPC_ADDR_NARROW_DATA:
         begin
            next_rdata[`DPC_OUT_SIX:`DPC_OUT_FOUR] = narrow_data[`DPC_OUT_SIX:`DPC_OUT_FOUR];
            next_rdata[`DPC_LINE_THREE+1:`DPC_LINE_ONE+1] = {line_three_val, line_two_val, line_one_val}; // see RQ4
         end
         `DPC_ADDR_WIDE_MODE: next_rdata = wide_dir;
         `DPC_ADDR_NARROW_MODE: next_rdata = narrow_mode_reg;
         `DPC_ADDR_PULLUP: next_rdata = wide_pullup_select;
         `DPC_ADDR_IRQ_EDGE: next_rdata[`DPC_IRQ_SEL_HI:`DPC_IRQ_SEL_LO] = irq_edge[`DPC_IRQ_SEL_HI:`DPC_IRQ_SEL_LO];
         `DPC_ADDR_STOP_SEL: next_rdata = stop_recovery_select;
         `DPC_ADDR_ADC_CTRL: next_rdata = adc_ctrl;
         `DPC_ADDR_ADC_RESULT: next_rdata = adc_result; // see RQ2
         default: next_rdata = `DPC_RESET_BYTE;
      endcase
   end

   // port_config is write-only and falls into the default
   always_ff @(posedge clock)
   begin
      if (reset)
         reg_rdata <= `DPC_RESET_BYTE;
      else if (clock_enable && reg_req.rd)
         reg_rdata <= next_rdata;
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wide_pin_out <= '0;
         wide_pin_oe <= '0;
         wide_pullup_en <= '0;
         adc_channel <= '0;
      end
      else if (clock_enable)
      begin
         wide_pin_out <= wide_data;
         wide_pin_oe <= ~wide_dir; // see RQ1
         wide_pullup_en <= wide_pullup_select & wide_dir; // see RQ3
         adc_channel <= adc_ctrl[`DPC_ADC_CH_HI:`DPC_ADC_CH_LO]; // see RQ2
      end
   end

   // timer output takes line six ahead of the wide-port handshake
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         narrow_pins <= '0;
         low_emi_mode <= 1'b0;
         analog_mode_en <= 1'b0;
      end
      else if (clock_enable)
      begin
         narrow_pins.four <= port_config[`DPC_PORT_CONFIG_COMP_OUT] ? comp_one_lvl : narrow_data[`DPC_OUT_FOUR]; // see RQ15
         narrow_pins.five <= narrow_mode_reg[`DPC_NMODE_P0_HS] ? p0_hs_out : narrow_data[`DPC_OUT_FIVE]; // see RQ12
         narrow_pins.six <= narrow_mode_reg[`DPC_NMODE_TIMER_OUT] ? timer_out : // see RQ11
            narrow_mode_reg[`DPC_NMODE_WIDE_HS] ? wide_hs_out : narrow_data[`DPC_OUT_SIX]; // see RQ12
         low_emi_mode <= narrow_mode_reg[`DPC_NMODE_LOW_EMI]; // see RQ5
         analog_mode_en <= analog;
      end
   end

   // no keeper on lines one-three: the raw pin level is all that is sampled
   assign timer_ext_in = narrow_lvl[`DPC_LINE_ONE]; // see RQ11
   assign wide_hs_in = narrow_lvl[`DPC_LINE_ONE]; // see RQ12
   assign p0_hs_in = narrow_lvl[`DPC_LINE_TWO]; // see RQ12
   assign comp_two_level = comp_two_lvl; // see RQ16

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset || !clock_enable);

   sequence seq_wide_all_in_read;
      reg_req.rd && (reg_req.addr == `DPC_ADDR_WIDE_DATA) && (wide_dir == `DPC_WIDE_DIR_RESET);
   endsequence

   sequence seq_line_three_fall;
      $fell(narrow_lvl[`DPC_LINE_THREE]) && !analog ##1 !analog;
   endsequence

   sequence seq_wdt_clear;
      watchdog_reset && !stop_mode;
   endsequence

   AST_PULLUP_FORCED_OFF: assert property ((wide_pullup_en & wide_pin_oe) == '0) // see RQ3
      else $error("pull-up enabled on a driven line");

   AST_INPUT_READBACK: assert property (seq_wide_all_in_read |=> reg_rdata == $past(wide_lvl)) // see RQ1
      else $error("input line read did not return pin level");

   AST_PORT_CONFIG_WDT_CLEAR: assert property (seq_wdt_clear |=> (port_config == `DPC_RESET_BYTE) ##1
      (narrow_pins.four == $past(narrow_data[`DPC_OUT_FOUR]))) // see RQ17
      else $error("watchdog reset did not clear port configuration");

   AST_PORT_CONFIG_STOP_HOLD: assert property (watchdog_reset && stop_mode && !port_config_write |=> $stable(port_config)) // see RQ17
      else $error("port configuration changed on stop-mode watchdog reset");

   AST_LINE_THREE_FALL: assert property (seq_line_three_fall |=> ext_request[`DPC_REQ_ONE]) // see RQ7
      else $error("falling edge on line three raised no request one");

   AST_BOTH_EDGES_ONE: assert property ((irq_edge[`DPC_IRQ_SEL_HI:`DPC_IRQ_SEL_LO] == 2'b11) && $changed(line_one_val)
      |-> ##2 ext_request[`DPC_REQ_TWO]) // see RQ9
      else $error("both-edge select missed an edge on line one");

   AST_FALL_ONLY_TWO: assert property ((irq_edge[`DPC_IRQ_SEL_HI:`DPC_IRQ_SEL_LO] == 2'b00) && $rose(line_two_val)
      |-> ##2 !ext_request[`DPC_REQ_ZERO]) // see RQ9
      else $error("falling-only select fired on a rising edge");

   AST_COMP_TO_PIN: assert property ($rose(comp_one_lvl) && port_config[`DPC_PORT_CONFIG_COMP_OUT] |=> narrow_pins.four) // see RQ15
      else $error("comparator one output not on line four");

   AST_ANALOG_TOGGLE: assert property (analog && stop_pulse |=>
      (line_three_toggle != $past(line_three_toggle)) && ext_request[`DPC_REQ_ONE]) // see RQ13
      else $error("recovery event did not toggle line three or raise request one");

   AST_LOW_EMI: assert property ($changed(narrow_mode_reg[`DPC_NMODE_LOW_EMI]) ##1 1'b1
      |-> low_emi_mode == $past(narrow_mode_reg[`DPC_NMODE_LOW_EMI])) // see RQ5
      else $error("low-emission mode output did not follow its bit");

endmodule : dpc_port_top

/* File: dpc_board.sv */
// board model: drives the eight-line port pins and six-line input lines one-three from the bench's settings
// assumes: the design's output enables decide who owns each eight-line pin
`timescale 1ns/1ps
module dpc_board
(
   input wire logic clock,
   input wire logic [7:0] wide_pin_out,
   input wire logic [7:0] wide_pin_oe,
   input wire logic [7:0] wide_pullup_en,
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   input wire logic [2:0] narrow_val,
   input wire logic narrow_en,
   output logic [7:0] wide_pin_in,
   output logic [2:0] narrow_pin_in
);
   logic [7:0] wide_last = 8'h00;
   logic [2:0] narrow_last = 3'h0;
   // a floating line without pull-up shows the inverse of its last level, so no stale value can pass
   assign wide_pin_in = (wide_pin_oe & wide_pin_out) | (~wide_pin_oe & ext_en & ext_val) |
      (~wide_pin_oe & ~ext_en & (wide_pullup_en | ~wide_last));
   // lines one to three have no keeper to hold a level
   assign narrow_pin_in = narrow_en ? narrow_val : ~narrow_last;
   always @(posedge clock)
   begin
      wide_last <= wide_pin_in;
      narrow_last <= narrow_pin_in;
   end
endmodule : dpc_board

/* File: test_dual_port_io_comparator.sv */
// self-checking bench for the dual port block, with a board model on the pin side
// assumes: dpc_pkg is compiled first and dpc_defs.svh is on the include path
`timescale 1ns/1ps
`include "dpc_defs.svh"
module test_dual_port_io_comparator
   import dpc_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   dpc_reg_req_s req = '0;
   dpc_byte_t reg_rdata;
   dpc_byte_t adc_result = 8'h00;
   dpc_byte_t rv;
   logic watchdog_reset = 1'b0;
   logic stop_mode = 1'b0;
   logic clock_enable = 1'b1;
   logic [7:0] wide_pin_in, wide_pin_out, wide_pin_oe, wide_pullup_en;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] ext_en = 8'hFF;
   logic [2:0] narrow_val = 3'h7;
   logic [2:0] narrow_pin_in, adc_channel, ext_request;
   logic comp_one_raw = 1'b0;
   logic comp_two_raw = 1'b0;
   logic [3:0] stop_src = 4'h0;
   logic timer_out = 1'b0;
   logic p0_hs_out = 1'b0;
   logic wide_hs_out = 1'b0;
   dpc_narrow_out_s narrow_pins;
   logic low_emi_mode, analog_mode_en, comp_two_level, timer_ext_in, p0_hs_in, wide_hs_in;
   int bad_count = 0;
   int checks_done = 0;
   int n0, n1, n2;

   dpc_port_top dut_u (.clock(clock), .reset(reset), .clock_enable(clock_enable), .reg_req(req), .reg_rdata(reg_rdata),
      .watchdog_reset(watchdog_reset), .stop_mode(stop_mode), .wide_pin_in(wide_pin_in),
      .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe), .wide_pullup_en(wide_pullup_en),
      .adc_channel(adc_channel), .adc_result(adc_result), .narrow_pin_in(narrow_pin_in),
      .comp_one_raw(comp_one_raw), .comp_two_raw(comp_two_raw), .narrow_pins(narrow_pins),
      .low_emi_mode(low_emi_mode), .analog_mode_en(analog_mode_en), .stop_src(stop_src),
      .ext_request(ext_request), .comp_two_level(comp_two_level), .timer_ext_in(timer_ext_in),
      .timer_out(timer_out), .p0_hs_in(p0_hs_in), .p0_hs_out(p0_hs_out), .wide_hs_in(wide_hs_in),
      .wide_hs_out(wide_hs_out));

   dpc_board board_u (.clock(clock), .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
      .wide_pullup_en(wide_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .narrow_val(narrow_val),
      .narrow_en(1'b1), .wide_pin_in(wide_pin_in), .narrow_pin_in(narrow_pin_in));

   initial forever #10 clock = ~clock;

   // request pulses last one cycle, so each is counted at the edge it stands
   always @(posedge clock)
   begin
      if (ext_request[0] === 1'b1) n0++;
      if (ext_request[1] === 1'b1) n1++;
      if (ext_request[2] === 1'b1) n2++;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask : settle

   task automatic clr();
      n0 = 0;
      n1 = 0;
      n2 = 0;
   endtask : clr

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      req <= '0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clock);
      req <= '0;
      @(negedge clock);
      rv = reg_rdata;
   endtask : rd

   task automatic pulse_line(input int idx);
      @(posedge clock);
      narrow_val[idx] <= 1'b0;
      settle(8);
      @(posedge clock);
      narrow_val[idx] <= 1'b1;
      settle(8);
   endtask : pulse_line

   task automatic t_reset();
      settle(1);
      chk(wide_pin_oe, 8'h00);
      chk(wide_pullup_en, 8'h00);
      chk(8'(narrow_pins), 8'h00);
      rd(`DPC_ADDR_PORT_CONFIG);
      chk(rv, 8'h00);
      wr(8'h1F, 8'hFF);
      rd(8'h1F);
      chk(rv, 8'h00);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_wide();
      wr(`DPC_ADDR_WIDE_MODE, 8'h0F);
      wr(`DPC_ADDR_WIDE_DATA, 8'hA5);
      wr(`DPC_ADDR_PULLUP, 8'hFF);
      @(posedge clock);
      ext_en <= 8'h03;
      ext_val <= 8'h02;
      settle(6);
      chk(wide_pin_oe, 8'hF0);
      chk(wide_pin_out & wide_pin_oe, 8'hA0);
      chk(wide_pullup_en, 8'h0F);
      rd(`DPC_ADDR_WIDE_DATA);
      chk(rv, 8'hAE);
      wr(`DPC_ADDR_WIDE_MODE, 8'hFF);
      settle(2);
      chk(wide_pullup_en, 8'hFF);
      // all lines inputs: undriven upper lines read high through their pull-ups
      settle(4);
      rd(`DPC_ADDR_WIDE_DATA);
      chk(rv, 8'hFE);
      wr(`DPC_ADDR_WIDE_MODE, 8'h00);
      settle(2);
      chk(wide_pullup_en, 8'h00);
      $display("t_wide done");
   endtask : t_wide

   task automatic t_adc();
      @(posedge clock);
      adc_result <= 8'h5A;
      for (int c = 0; c < 8; c++)
      begin
         wr(`DPC_ADDR_ADC_CTRL, 8'(c));
         settle(1);
         chk(8'(adc_channel), 8'(c));
      end
      rd(`DPC_ADDR_ADC_RESULT);
      chk(rv, 8'h5A);
      $display("t_adc done");
   endtask : t_adc

   task automatic t_edges();
      logic [1:0] e;
      for (int i = 0; i < 4; i++)
      begin
         e = 2'(i);
         wr(`DPC_ADDR_IRQ_EDGE, {e, 6'h00});
         settle(8);
         clr();
         pulse_line(0);
         chk(8'(n2), 8'(int'(e != 2'b10) + int'(e[1])));
         chk(8'(n0), 8'h00);
         clr();
         pulse_line(1);
         chk(8'(n0), 8'(int'(e != 2'b01) + int'(e[0])));
         chk(8'(n2), 8'h00);
      end
      clr();
      pulse_line(2);
      chk(8'(n1), 8'h01);
      $display("t_edges done");
   endtask : t_edges

   task automatic t_analog();
      wr(`DPC_ADDR_IRQ_EDGE, 8'hC0);
      wr(`DPC_ADDR_STOP_SEL, 8'h00);
      wr(`DPC_ADDR_NARROW_MODE, 8'h02);
      settle(8);
      chk(8'(analog_mode_en), 8'h01);
      clr();
      pulse_line(0);
      pulse_line(2);
      chk(8'(n2), 8'h00);
      chk(8'(n1), 8'h00);
      @(posedge clock);
      comp_one_raw <= 1'b1;
      comp_two_raw <= 1'b1;
      stop_src <= 4'h1;
      settle(1);
      chk(8'(comp_two_level), 8'h00);
      settle(7);
      chk(8'(comp_two_level), 8'h01);
      chk({2'h0, n2[1:0], n1[1:0], n0[1:0]}, 8'h15);
      rd(`DPC_ADDR_NARROW_DATA);
      chk(8'(rv[3:1]), 8'h07);
      @(posedge clock);
      comp_one_raw <= 1'b0;
      stop_src <= 4'h0;
      wr(`DPC_ADDR_NARROW_MODE, 8'h00);
      settle(8);
      $display("t_analog done");
   endtask : t_analog

   task automatic t_outputs();
      wr(`DPC_ADDR_NARROW_DATA, 8'h10);
      settle(2);
      chk(8'(narrow_pins), 8'h01);
      wr(`DPC_ADDR_PORT_CONFIG, 8'h01);
      settle(6);
      chk(8'(narrow_pins.four), 8'h00);
      @(posedge clock);
      comp_one_raw <= 1'b1;
      settle(6);
      chk(8'(narrow_pins.four), 8'h01);
      @(posedge clock);
      comp_one_raw <= 1'b0;
      timer_out <= 1'b1;
      narrow_val <= 3'b001;
      wr(`DPC_ADDR_NARROW_MODE, 8'h29);
      settle(6);
      chk(8'(low_emi_mode), 8'h01);
      chk({6'h0, narrow_pins.five, narrow_pins.six}, 8'h01);
      chk({5'h0, timer_ext_in, wide_hs_in, p0_hs_in}, 8'h06);
      @(posedge clock);
      timer_out <= 1'b0;
      p0_hs_out <= 1'b1;
      settle(2);
      chk({6'h0, narrow_pins.five, narrow_pins.six}, 8'h02);
      wr(`DPC_ADDR_NARROW_MODE, 8'h04);
      @(posedge clock);
      wide_hs_out <= 1'b1;
      settle(2);
      chk({6'h0, low_emi_mode, narrow_pins.six}, 8'h01);
      $display("t_outputs done");
   endtask : t_outputs

   task automatic t_watchdog();
      @(posedge clock);
      stop_mode <= 1'b1;
      watchdog_reset <= 1'b1;
      @(posedge clock);
      stop_mode <= 1'b0;
      watchdog_reset <= 1'b0;
      settle(4);
      chk(8'(narrow_pins.four), 8'h00);
      @(posedge clock);
      watchdog_reset <= 1'b1;
      @(posedge clock);
      watchdog_reset <= 1'b0;
      settle(2);
      chk(8'(narrow_pins.four), 8'h01);
      // a write while the enable is low must leave the output latch alone
      @(posedge clock);
      clock_enable <= 1'b0;
      wr(`DPC_ADDR_NARROW_DATA, 8'h00);
      @(posedge clock);
      clock_enable <= 1'b1;
      settle(2);
      chk(8'(narrow_pins), 8'h05);
      $display("t_watchdog done");
   endtask : t_watchdog

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // whole run is a few hundred cycles; this span is generous
   initial
   begin
      #400_000;
      bad_count++;
      end_sim();
   end

   initial
   begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_wide();
      t_adc();
      t_edges();
      t_analog();
      t_outputs();
      t_watchdog();
      end_sim();
   end
endmodule : test_dual_port_io_comparator
